/* rtl/sfu_pkg.sv */
/*
  Shared constants and types of the scientific float unit.
  Assumes a 48-bit float word: 12-bit exponent on top, then mantissa
  sign, then a 35-bit magnitude fraction.
*/
package sfu_pkg;
  localparam int MAG_W = 35; // Mantissa magnitude bits
  localparam int MAN_W = 36; // Mantissa sign plus magnitude
  localparam int EXP_W = 12; // Exponent bits, twos complement
  localparam int FLT_W = 48; // Float word bits
  localparam int INT_W = 24; // Binary integer field bits
  localparam int DEC_N = 11; // Decimal field digits
  localparam int DIV_NW = 70; // Divider numerator bits
  // Operation codes
  localparam logic [5:0] OP_SHIFT = 6'h04;
  localparam logic [5:0] OP_IMUL = 6'h05;
  localparam logic [5:0] OP_ACC = 6'h06;
  localparam logic [5:0] OP_MEM = 6'h07;
  // Function variants
  localparam logic [5:0] FN_DTB = 6'h03;
  localparam logic [5:0] FN_BRC = 6'h04;
  localparam logic [5:0] FN_BRI = 6'h05;
  localparam logic [5:0] FN_BTD = 6'h06;
  localparam logic [5:0] FN_DIV = 6'h0a;
  // Exponent limits and integer exponent
  localparam logic signed [13:0] EXP_MAX = 14'sh07ff;
  localparam logic signed [13:0] EXP_MIN = -14'sh0800;
  localparam logic signed [13:0] EXP_INT = 14'sh0023;
  // Address steps per field length
  localparam int FLD_FLT = 8;
  localparam int FLD_DEC = 11;
  localparam int FLD_INT = 4;
  // Indicator bit positions
  localparam int IND_MPY = 0;
  localparam int IND_EXP = 1;
  localparam int IND_DIV = 2;
  // Shift mode digit fields
  localparam int SM_RIGHT = 0;
  localparam int SM_DP = 1;
  localparam int SM_ARITH = 2;
  // Load/read select of the low-order result register
  localparam logic [2:0] SEL_LOR = 3'h4;
  // Reset values
  localparam logic [47:0] FLT_RST = 48'h0;
  localparam logic [2:0] IND_RST = 3'h0;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DIV = 2'b01,
    S_SHIFT = 2'b10
  } sfu_state_t;
endpackage : sfu_pkg

/* rtl/sfu_seq_div.sv */
/*
  Sequential restoring divider, one numerator bit per clock.
  Assumes den_i is nonzero and start_i is raised only when idle.
*/
`timescale 1ns/1ps
module sfu_seq_div #(
  parameter int NW = 70,
  parameter int DW = 35
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic start_i, // Begin a division
  input wire logic [NW-1:0] num_i, // Numerator
  input wire logic [DW-1:0] den_i, // Denominator
  output logic done_o, // One-cycle finish pulse
  output logic [NW-1:0] quo_o, // Quotient
  output logic [DW-1:0] rem_o, // Remainder
  output logic busy_o // Division running
);
  localparam int CW = $clog2(NW + 1);
  if (NW < DW) begin : g_bad_width
    $error("sfu_seq_div: NW must not be below DW");
  end
  logic [NW-1:0] n_r; // Numerator bits still to bring down
  logic [NW-1:0] q_r; // Quotient being built
  logic [DW:0] r_r; // Partial remainder
  logic [DW-1:0] d_r; // Held denominator
  logic [CW-1:0] cnt_r; // Bits left
  logic busy_r; // Running
  logic done_r; // Finish pulse
  logic [DW:0] trial; // Remainder with next bit
  logic fits; // Denominator goes into trial

  assign trial = {r_r[DW-1:0], n_r[NW-1]};
  assign fits = trial >= {1'b0, d_r};

  // Iteration; remainder stays below the denominator
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      n_r <= '0;
      q_r <= '0;
      r_r <= '0;
      d_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && cnt_r == CW'(1);
      if (start_i && !busy_r) begin
        n_r <= num_i;
        d_r <= den_i;
        r_r <= '0;
        q_r <= '0;
        cnt_r <= CW'(NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        n_r <= {n_r[NW-2:0], 1'b0};
        r_r <= fits ? trial - {1'b0, d_r} : trial;
        q_r <= {q_r[NW-2:0], fits};
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == CW'(1)) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  assign done_o = done_r;
  assign quo_o = q_r;
  assign rem_o = r_r[DW-1:0];
  assign busy_o = busy_r;
endmodule : sfu_seq_div

/* rtl/sfu_top.sv */
/*
  Scientific float unit: divide, conversions, branch tests, mantissa
  shifts and integer multiply, with accumulators and indicators.
  Assumes the sequencer presents decoded instructions and operands and
  waits on CMD_READY_O; memory fields arrive and leave as whole words.
*/
// Overview of operation
// - Memory word over X, quotient Y, remainder low
// - Y over X, quotient Y, remainder low
// - Remainder keeps dividend sign, exponent rule
// - Prenormalize operands, postnormalize quotient, indicators
// - Decimal field to integer, exponent 35 plus overflow bit count
// - Overflow bits move into low register
// - Low register sign zero, exponent the overflow bit count
// - X mantissa to decimal field, exponent kept
// - Condition digit selects test on X
// - Tested indicators cleared always
// - Mode digit picks direction, precision, kind
// - Second variant gives count up to 63
// - Shift zeroes exponents, arithmetic keeps signs
// - Multiply 24-bit fields, product to B
// - Address registers end at A-4, B-4
// - Product over 24 bits sets overflow
// - Zero divisor sets check, nothing altered
// - Exponent overflow wraps, underflow gives zero
`timescale 1ns/1ps
module sfu_top #(
  parameter int ADDR_W = 18,
  parameter bit PRENORM_DVD = 1'b1
) (
  input wire logic SYS_CLK_I, // 20 MHz clock
  input wire logic NRST_I, // Synchronous reset, active low
  input wire logic CMD_VALID_I, // Instruction offered
  output logic CMD_READY_O, // Unit idle, takes instruction
  input wire logic [5:0] OP_I, // Operation code
  input wire logic [5:0] VAR1_I, // First variant, X and Y
  input wire logic [5:0] VAR2_I, // Function or shift count
  input wire logic [ADDR_W-1:0] A_ADDR_I, // A address
  input wire logic [ADDR_W-1:0] B_ADDR_I, // B address
  input wire logic [47:0] MEM_WORD_I, // Memory float word
  input wire logic [43:0] DEC_DIGITS_I, // Decimal field digits
  input wire logic DEC_NEG_I, // Decimal field sign
  input wire logic [23:0] INT_A_I, // Integer field at A
  input wire logic [23:0] INT_B_I, // Integer field at B
  input wire logic LD_I, // Load accumulator or low reg
  input wire logic [2:0] LD_SEL_I, // 0-3 accumulator, 4 low reg
  input wire logic [47:0] LD_DATA_I, // Load word
  input wire logic [2:0] RD_SEL_I, // Readback select
  output logic [47:0] RD_DATA_O, // Readback word
  output logic DONE_O, // Instruction finished pulse
  output logic BRANCH_O, // Branch to A, with DONE_O
  output logic [ADDR_W-1:0] AAR_O, // A address register after
  output logic [ADDR_W-1:0] BAR_O, // B address register after
  output logic DEC_WR_O, // Decimal field write pulse
  output logic [43:0] DEC_DIGITS_O, // Decimal digits out
  output logic DEC_NEG_O, // Decimal sign out
  output logic PROD_WR_O, // Product write pulse
  output logic [23:0] PROD_O, // Product for B field
  output logic MPY_OVF_O, // Multiply overflow indicator
  output logic EXP_OVF_O, // Exponent overflow indicator
  output logic DIV_CHK_O // Divide check indicator
);
  if (ADDR_W < 4) begin : g_bad_addr
    $error("sfu_top: ADDR_W too small");
  end

  // Leading zero count of a magnitude
  function automatic logic [5:0] lead_zeros(input logic [34:0] m);
    lead_zeros = 6'(sfu_pkg::MAG_W);
    for (int i = 0; i < sfu_pkg::MAG_W; i++) begin
      if (m[i]) lead_zeros = 6'(sfu_pkg::MAG_W - 1 - i);
    end
  endfunction : lead_zeros

  // Signed exponent of a float word
  function automatic logic signed [13:0] exp_of(input logic [47:0] w);
    exp_of = $signed({{2{w[47]}}, w[47:36]});
  endfunction : exp_of

  // Build a word; bit 48 flags exponent overflow
  function automatic logic [48:0] pack_flt(input logic s,
      input logic [34:0] m, input logic signed [13:0] e);
    pack_flt = '0;
    if (m != '0 && e >= sfu_pkg::EXP_MIN) begin
      pack_flt = {e > sfu_pkg::EXP_MAX, e[11:0], s, m};
    end
  endfunction : pack_flt

  // Decimal digits to binary
  function automatic logic [36:0] dec_to_bin(input logic [43:0] d);
    dec_to_bin = '0;
    for (int i = sfu_pkg::DEC_N - 1; i >= 0; i--) begin
      dec_to_bin = 37'(dec_to_bin * 37'h0a) + 37'(d[i*4 +: 4]);
    end
  endfunction : dec_to_bin

  // Binary to decimal digits, shift and add three
  function automatic logic [43:0] bin_to_dec(input logic [34:0] b);
    bin_to_dec = '0;
    for (int i = sfu_pkg::MAG_W - 1; i >= 0; i--) begin
      for (int k = 0; k < sfu_pkg::DEC_N; k++) begin
        if (bin_to_dec[k*4 +: 4] > 4'h4) begin
          bin_to_dec[k*4 +: 4] = bin_to_dec[k*4 +: 4] + 4'h3;
        end
      end
      bin_to_dec = {bin_to_dec[42:0], b[i]};
    end
  endfunction : bin_to_dec

  // One-position mantissa shift; returns {X, low} mantissas
  function automatic logic [71:0] shift_one(input logic [35:0] x,
      input logic [35:0] l, input logic [2:0] md);
    logic [71:0] w;
    logic [69:0] g;
    w = {x, l};
    g = {x[34:0], l[34:0]};
    case ({md[sfu_pkg::SM_ARITH], md[sfu_pkg::SM_DP],
           md[sfu_pkg::SM_RIGHT]})
      3'h0: shift_one = {x[34:0], x[35], l};
      3'h1: shift_one = {x[0], x[35:1], l};
      3'h2: shift_one = {w[70:0], w[71]};
      3'h3: shift_one = {w[0], w[71:1]};
      // Arithmetic forms keep both signs in place
      3'h4: shift_one = {x[35], x[33:0], 1'b0, l};
      3'h5: shift_one = {x[35], 1'b0, x[34:1], l};
      3'h6: shift_one = {x[35], g[68:34], l[35], g[33:0], 1'b0};
      3'h7: shift_one = {x[35], 1'b0, g[69:36], l[35], g[35:1]};
      default: shift_one = w;
    endcase
  endfunction : shift_one

  sfu_pkg::sfu_state_t state_r; // Sequencing state
  logic [47:0] acc_r [0:3]; // Floating accumulators
  logic [47:0] lor_r; // Low-order result register
  logic [2:0] ind_r; // Indicators {div, exp, mpy}
  logic [2:0] ind_set, ind_clr; // Indicator events
  logic [47:0] acc_x, acc_y; // Selected operands, 4-7 read zero
  logic issue, is_mem, is_acc; // Decode
  logic op_div, op_dtb, op_btd, op_brc, op_bri, op_shf, op_mul;
  logic [47:0] dvd, dvs; // Dividend, divisor
  logic [5:0] nd, nv; // Normalizing shifts
  logic [34:0] md, mv; // Normalized magnitudes
  logic signed [13:0] ed, ev; // Adjusted exponents
  logic big, gt, dv_zero, dv_start, dv_done; // Divide control
  logic [69:0] dv_num, dv_quo; // Divider numerator, quotient
  logic [34:0] dv_rem, q, qm; // Remainder, raw and normal quotient
  logic [5:0] qn; // Quotient normalizing shift
  logic signed [13:0] dq_exp_r, dr_exp_r, qe; // Divide exponents
  logic dq_sgn_r, dr_sgn_r; // Divide signs
  logic [2:0] dy_r; // Divide destination
  logic [48:0] qpk, rpk; // Packed quotient and remainder
  logic [36:0] dtb_v; // Converted integer
  logic [1:0] dtb_ov; // Overflow bit count
  logic [47:0] dtb_y, dtb_l; // Conversion results
  logic [5:0] dtb_sh; // Low-bit placement
  logic [47:0] prod; // Full integer product
  logic cond_hit; // Branch condition met
  logic [35:0] sx_r, sl_r; // Shift work mantissas
  logic [5:0] scnt_r; // Positions left
  logic [2:0] smode_r, sxi_r; // Shift mode and X index
  logic done_r, branch_r, dec_wr_r, prod_wr_r; // Output pulses
  logic [ADDR_W-1:0] aar_r, bar_r; // Address registers
  logic [43:0] dec_r; // Decimal digits out
  logic dec_neg_r; // Decimal sign out
  logic [23:0] prod_r; // Product out
  logic [47:0] rd_r; // Readback

  assign acc_x = VAR1_I[5] ? '0 : acc_r[VAR1_I[4:3]];
  assign acc_y = VAR1_I[2] ? '0 : acc_r[VAR1_I[1:0]];
  assign CMD_READY_O = state_r == sfu_pkg::S_IDLE;
  assign issue = CMD_VALID_I && CMD_READY_O;
  assign is_mem = OP_I == sfu_pkg::OP_MEM;
  assign is_acc = OP_I == sfu_pkg::OP_ACC;
  assign op_div = (is_mem || is_acc) && VAR2_I == sfu_pkg::FN_DIV;
  assign op_dtb = is_mem && VAR2_I == sfu_pkg::FN_DTB;
  assign op_btd = is_mem && VAR2_I == sfu_pkg::FN_BTD;
  assign op_brc = is_mem && VAR2_I == sfu_pkg::FN_BRC;
  assign op_bri = is_mem && VAR2_I == sfu_pkg::FN_BRI;
  assign op_shf = OP_I == sfu_pkg::OP_SHIFT;
  assign op_mul = OP_I == sfu_pkg::OP_IMUL;

  // Divide operand preparation
  assign dvd = is_mem ? MEM_WORD_I : acc_y;
  assign dvs = acc_x;
  assign nd = PRENORM_DVD ? lead_zeros(dvd[34:0]) : 6'h00;
  assign nv = lead_zeros(dvs[34:0]);
  assign md = 35'(dvd[34:0] << nd);
  assign mv = 35'(dvs[34:0] << nv);
  assign ed = exp_of(dvd) - $signed({8'h00, nd});
  assign ev = exp_of(dvs) - $signed({8'h00, nv});
  assign big = md >= mv;
  assign gt = md > mv;
  assign dv_zero = dvs[34:0] == '0;
  // Shift the numerator down one when the ratio would reach one
  assign dv_num = big ? {1'b0, md, 34'h0} : {md, 35'h0};
  assign dv_start = issue && op_div && !dv_zero;

  sfu_seq_div #(.NW(sfu_pkg::DIV_NW), .DW(sfu_pkg::MAG_W)) u_div (
    .clk_i(SYS_CLK_I),
    .rst_n_i(NRST_I),
    .start_i(dv_start),
    .num_i(dv_num),
    .den_i(mv),
    .done_o(dv_done),
    .quo_o(dv_quo),
    .rem_o(dv_rem),
    .busy_o()
  );

  // Quotient postnormalized whether or not the dividend was
  assign q = dv_quo[34:0];
  assign qn = lead_zeros(q);
  assign qm = 35'(q << qn);
  assign qe = dq_exp_r - $signed({8'h00, qn});
  assign qpk = pack_flt(dq_sgn_r, qm, qe);
  assign rpk = pack_flt(dr_sgn_r, dv_rem, dr_exp_r);

  // Decimal to binary; one or two bits may overflow the magnitude
  assign dtb_v = dec_to_bin(DEC_DIGITS_I);
  assign dtb_ov = dtb_v[36] ? 2'h2 : (dtb_v[35] ? 2'h1 : 2'h0);
  assign dtb_sh = 6'(sfu_pkg::MAG_W) - {4'h0, dtb_ov};
  assign dtb_y = {12'(sfu_pkg::EXP_INT) + {10'h000, dtb_ov},
                  DEC_NEG_I && dtb_v != '0,
                  35'(dtb_v >> dtb_ov)};
  assign dtb_l = {{10'h000, dtb_ov}, 1'b0,
                  35'(dtb_v << dtb_sh)};

  assign prod = INT_A_I * INT_B_I;

  // Condition test on X; a normalized X is the program's duty
  always_comb begin
    case (VAR1_I[2:0])
      3'h0: cond_hit = 1'b0;
      3'h1: cond_hit = acc_x[34:0] == '0;
      3'h2: cond_hit = acc_x[35] && acc_x[34:0] != '0;
      3'h3: cond_hit = acc_x[35] || acc_x[34:0] == '0;
      3'h4: cond_hit = !(acc_x[35] && acc_x[34:0] != '0);
      3'h5: cond_hit = acc_x[34:0] != '0;
      3'h6: cond_hit = !acc_x[35] && acc_x[34:0] != '0;
      default: cond_hit = 1'b1;
    endcase
  end

  // Indicator events
  always_comb begin
    ind_set = '0;
    ind_clr = '0;
    if (issue && op_div && dv_zero) ind_set[sfu_pkg::IND_DIV] = 1'b1;
    if (issue && op_mul && prod[47:24] != '0) begin
      ind_set[sfu_pkg::IND_MPY] = 1'b1;
    end
    if (state_r == sfu_pkg::S_DIV && dv_done && (qpk[48] || rpk[48])) begin
      ind_set[sfu_pkg::IND_EXP] = 1'b1;
    end
    if (issue && op_bri) ind_clr = VAR1_I[2:0];
  end

  // Indicators; a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) ind_r <= sfu_pkg::IND_RST;
    else ind_r <= (ind_r & ~ind_clr) | ind_set;
  end

  // Sequencing state and divide context
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_r <= sfu_pkg::S_IDLE;
      dq_exp_r <= '0;
      dr_exp_r <= '0;
      dq_sgn_r <= 1'b0;
      dr_sgn_r <= 1'b0;
      dy_r <= '0;
    end else begin
      case (state_r)
        sfu_pkg::S_IDLE: begin
          if (issue && op_shf) state_r <= sfu_pkg::S_SHIFT;
          else if (dv_start) state_r <= sfu_pkg::S_DIV;
          if (dv_start) begin
            dq_exp_r <= ed - ev + $signed({13'h0000, big});
            dr_exp_r <= ed - sfu_pkg::EXP_INT + $signed({13'h0000, gt});
            dq_sgn_r <= dvd[35] ^ dvs[35];
            dr_sgn_r <= dvd[35];
            dy_r <= VAR1_I[2:0];
          end
        end
        sfu_pkg::S_DIV: if (dv_done) state_r <= sfu_pkg::S_IDLE;
        sfu_pkg::S_SHIFT: if (scnt_r == '0) state_r <= sfu_pkg::S_IDLE;
        default: state_r <= sfu_pkg::S_IDLE;
      endcase
    end
  end

  // Shift work registers, one position per clock
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      sx_r <= '0;
      sl_r <= '0;
      scnt_r <= '0;
      smode_r <= '0;
      sxi_r <= '0;
    end else if (issue && op_shf) begin
      sx_r <= acc_x[35:0];
      sl_r <= lor_r[35:0];
      scnt_r <= VAR2_I;
      smode_r <= VAR1_I[2:0];
      sxi_r <= VAR1_I[5:3];
    end else if (state_r == sfu_pkg::S_SHIFT && scnt_r != '0) begin
      {sx_r, sl_r} <= shift_one(sx_r, sl_r, smode_r);
      scnt_r <= scnt_r - 6'h01;
    end
  end

  // Accumulators and low register; unit results beat loads
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 4; i++) acc_r[i] <= sfu_pkg::FLT_RST;
      lor_r <= sfu_pkg::FLT_RST;
    end else if (state_r == sfu_pkg::S_DIV && dv_done) begin
      if (!dy_r[2]) acc_r[dy_r[1:0]] <= qpk[47:0];
      lor_r <= rpk[47:0];
    end else if (state_r == sfu_pkg::S_SHIFT && scnt_r == '0) begin
      if (!sxi_r[2]) acc_r[sxi_r[1:0]] <= {12'h000, sx_r};
      lor_r <= {12'h000, sl_r};
    end else if (issue && op_dtb) begin
      if (!VAR1_I[2]) acc_r[VAR1_I[1:0]] <= dtb_y;
      lor_r <= dtb_l;
    end else if (LD_I) begin
      if (LD_SEL_I == sfu_pkg::SEL_LOR) lor_r <= LD_DATA_I;
      else if (!LD_SEL_I[2]) acc_r[LD_SEL_I[1:0]] <= LD_DATA_I;
    end
  end

  // Completion pulses, address registers and field results
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      done_r <= 1'b0;
      branch_r <= 1'b0;
      dec_wr_r <= 1'b0;
      prod_wr_r <= 1'b0;
      aar_r <= '0;
      bar_r <= '0;
      dec_r <= '0;
      dec_neg_r <= 1'b0;
      prod_r <= '0;
    end else begin
      done_r <= (issue && !op_shf && !dv_start)
             || (state_r == sfu_pkg::S_DIV && dv_done)
             || (state_r == sfu_pkg::S_SHIFT && scnt_r == '0);
      branch_r <= issue && ((op_brc && cond_hit)
               || (op_bri && (ind_r & VAR1_I[2:0]) != '0));
      dec_wr_r <= issue && op_btd;
      prod_wr_r <= issue && op_mul;
      if (issue) begin
        aar_r <= A_ADDR_I;
        bar_r <= B_ADDR_I;
        if ((op_div && is_mem) || (is_mem && VAR2_I == 6'h00)) begin
          aar_r <= A_ADDR_I - ADDR_W'(sfu_pkg::FLD_FLT);
        end
        if (op_dtb || op_btd) begin
          aar_r <= A_ADDR_I - ADDR_W'(sfu_pkg::FLD_DEC);
        end
        if (op_mul) begin
          aar_r <= A_ADDR_I - ADDR_W'(sfu_pkg::FLD_INT);
          bar_r <= B_ADDR_I - ADDR_W'(sfu_pkg::FLD_INT);
          prod_r <= prod[23:0];
        end
        if (op_btd) begin
          dec_r <= bin_to_dec(acc_x[34:0]);
          dec_neg_r <= acc_x[35] && acc_x[34:0] != '0;
        end
      end
    end
  end

  // Registered readback; unmapped selects read zero
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) rd_r <= '0;
    else if (RD_SEL_I == sfu_pkg::SEL_LOR) rd_r <= lor_r;
    else if (RD_SEL_I[2]) rd_r <= '0;
    else rd_r <= acc_r[RD_SEL_I[1:0]];
  end

  assign RD_DATA_O = rd_r;
  assign DONE_O = done_r;
  assign BRANCH_O = branch_r;
  assign AAR_O = aar_r;
  assign BAR_O = bar_r;
  assign DEC_WR_O = dec_wr_r;
  assign DEC_DIGITS_O = dec_r;
  assign DEC_NEG_O = dec_neg_r;
  assign PROD_WR_O = prod_wr_r;
  assign PROD_O = prod_r;
  assign MPY_OVF_O = ind_r[sfu_pkg::IND_MPY];
  assign EXP_OVF_O = ind_r[sfu_pkg::IND_EXP];
  assign DIV_CHK_O = ind_r[sfu_pkg::IND_DIV];
endmodule : sfu_top

/* verif/sfu_properties.sv */
/*
  Port checker of the float unit.
  Assumes one clock, synchronous low reset.
*/
`timescale 1ns/1ps
module sfu_properties #(
  parameter int ADDR_W = 18
) (
  input wire logic SYS_CLK_I, // Clock
  input wire logic NRST_I, // Reset, active low
  input wire logic CMD_VALID_I, // Offered
  input wire logic CMD_READY_O, // Idle
  input wire logic [5:0] OP_I, // Op code
  input wire logic [5:0] VAR1_I, // First variant
  input wire logic [5:0] VAR2_I, // Second variant
  input wire logic [ADDR_W-1:0] A_ADDR_I, // A address
  input wire logic [ADDR_W-1:0] B_ADDR_I, // B address
  input wire logic [23:0] INT_A_I, // Field at A
  input wire logic [23:0] INT_B_I, // Field at B
  input wire logic DONE_O, // Finished
  input wire logic BRANCH_O, // Branch taken
  input wire logic [ADDR_W-1:0] AAR_O, // A register
  input wire logic [ADDR_W-1:0] BAR_O, // B register
  input wire logic DEC_WR_O, // Decimal write
  input wire logic PROD_WR_O, // Product write
  input wire logic MPY_OVF_O, // Mult overflow
  input wire logic EXP_OVF_O, // Exp overflow
  input wire logic DIV_CHK_O // Divide check
);
  wire take = CMD_VALID_I && CMD_READY_O; // Taken
  wire mem = take && OP_I == sfu_pkg::OP_MEM; // Memory form
  wire imul = take && OP_I == sfu_pkg::OP_IMUL; // Multiply
  wire bri = mem && VAR2_I == sfu_pkg::FN_BRI; // Indicator test
  wire brc = mem && VAR2_I == sfu_pkg::FN_BRC; // Condition test
  wire [2:0] msk = VAR1_I[2:0]; // Low digit
  wire [2:0] ind = {DIV_CHK_O, EXP_OVF_O, MPY_OVF_O}; // Indicators
  wire hit = |(ind & msk); // Selected indicator set
  // Product past 24 bits
  wire prod_hi = (48'(INT_A_I) * 48'(INT_B_I)) >> 24 != 48'h0;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  a_prod_done: assert property (PROD_WR_O |-> DONE_O)
    else $error("product write without done");
  a_mult_addr: assert property (imul |=> DONE_O &&
    AAR_O == ADDR_W'($past(A_ADDR_I) - 4) &&
    BAR_O == ADDR_W'($past(B_ADDR_I) - 4)) else $error("mult addr");
  a_mult_ovf: assert property (imul && prod_hi |=> MPY_OVF_O)
    else $error("mult overflow missing");
  a_ind_branch: assert property (bri |=> BRANCH_O == $past(hit))
    else $error("indicator branch wrong");
  a_ind_clear: assert property (bri |=> (ind & $past(msk)) == 3'h0)
    else $error("tested indicator kept");
  a_cond_fixed: assert property (brc && (msk == 3'h7 ||
    msk == 3'h0) |=> BRANCH_O == ($past(msk) == 3'h7))
    else $error("fixed condition wrong");
  a_branch_done: assert property (BRANCH_O |-> DONE_O)
    else $error("branch without done");
  a_btd_write: assert property (mem && VAR2_I == sfu_pkg::FN_BTD
    |=> DEC_WR_O && AAR_O == ADDR_W'($past(A_ADDR_I) - 11))
    else $error("decimal write wrong");
  a_dtb_addr: assert property (mem && VAR2_I == sfu_pkg::FN_DTB
    |=> DONE_O && AAR_O == ADDR_W'($past(A_ADDR_I) - 11))
    else $error("conversion address wrong");
  a_shift_time: assert property (take && OP_I == sfu_pkg::OP_SHIFT
    && VAR2_I == 6'h04 |=> !DONE_O [*5] ##1 DONE_O)
    else $error("shift length wrong");
  c_mult_ovf: cover property (imul && prod_hi);
  c_ind_hit: cover property (bri && hit);
  c_shift: cover property (take && OP_I == sfu_pkg::OP_SHIFT);
endmodule : sfu_properties

/* verif/sfu_seq_model.sv */
/*
  Sequencer side: holds an instruction till taken, waits for done.
  Released fields go stale.
*/
`timescale 1ns/1ps
module sfu_seq_model (
  input wire logic clk_i, // Clock
  input wire logic ready_i, // Unit idle
  input wire logic done_i, // Finished
  output logic valid_o, // Offered
  output logic [5:0] op_o, // Op code
  output logic [5:0] v1_o, // First variant
  output logic [5:0] v2_o, // Second variant
  output logic [47:0] mem_o, // Float word at A
  output logic [43:0] dig_o, // Decimal digits
  output logic neg_o, // Decimal sign
  output logic [23:0] ia_o, // Field at A
  output logic [23:0] ib_o // Field at B
);
  assign mem_o = {12'h004, 1'b0, 35'h400000000}; // Normal eight
  initial {valid_o, op_o, v1_o, v2_o, dig_o, neg_o, ia_o, ib_o} = 112'h0;
  task automatic issue(input logic [5:0] op, input logic [5:0] v1,
      input logic [5:0] v2, input logic [47:0] ab,
      input logic [44:0] dd, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    #1;
    {op_o, v1_o, v2_o, ia_o, ib_o} = {op, v1, v2, ab};
    {neg_o, dig_o} = dd;
    valid_o = 1'b1;
    for (n = 0; n < 300 && !ok; n++) begin
      ok = ready_i;
      @(posedge clk_i);
    end
    #1;
    valid_o = 1'b0;
    {ia_o, ib_o, dig_o} = ~{ia_o, ib_o, dig_o}; // Released
    ok = 1'b0;
    for (n = 0; n < 300 && !ok; n++) begin
      // Done may already stand one step after the taking edge
      ok = done_i;
      if (!ok) #50;
    end
  endtask : issue
endmodule : sfu_seq_model

/* verif/scientific_float_unit_tb.sv */
/*
  Float unit bench.
  Assumes the sequencer model drives instructions.
*/
`timescale 1ns/1ps
module scientific_float_unit_tb;
  typedef struct packed {logic [5:0] v1; logic [5:0] v2;
    logic br;} sfu_row_t;
  localparam logic [47:0] TWO = {12'h002, 1'b0, 35'h400000000};
  localparam logic [47:0] FOUR = {12'h003, 1'b0, 35'h400000000};
  localparam logic [47:0] DTB_Y = {12'h023, 1'b0, 35'h3039};
  logic clk = 1'b0, rst_n = 1'b0, ld_en = 1'b0; // Clock, reset, load
  logic [2:0] ld_sel = 3'h0, rd_sel = 3'h0; // Selects
  logic [47:0] ld_data = 48'h0, mw, rd; // Words
  logic valid, rdy, done, br, decw, decn, dn, pw; // Strobes
  logic [5:0] op, v1, v2; // Instruction
  logic [43:0] dd, decd; // Digits
  logic [23:0] ia, ib, prod; // Integer fields
  logic [17:0] a_address_register, bar; // Address registers
  logic [2:0] ind; // Divide, exp, mult
  int failures = 0, checks = 0;
  // Branch rows; indicators clear, X zero
  sfu_row_t rows [10] = '{'{6'o0, 6'h04, 0}, '{6'o1, 6'h04, 1},
    '{6'o2, 6'h04, 0}, '{6'o3, 6'h04, 1}, '{6'o4, 6'h04, 1},
    '{6'o5, 6'h04, 0}, '{6'o6, 6'h04, 0}, '{6'o7, 6'h04, 1},
    '{6'o0, 6'h05, 0}, '{6'o7, 6'h05, 0}};
  always #25 clk = ~clk;
  sfu_seq_model mdl_u (.clk_i(clk), .ready_i(rdy), .done_i(done),
    .valid_o(valid), .op_o(op), .v1_o(v1), .v2_o(v2), .mem_o(mw),
    .dig_o(dd), .neg_o(dn), .ia_o(ia), .ib_o(ib));
  sfu_top dut_u (.SYS_CLK_I(clk), .NRST_I(rst_n), .CMD_VALID_I(valid),
    .CMD_READY_O(rdy), .OP_I(op), .VAR1_I(v1), .VAR2_I(v2),
    .A_ADDR_I(18'h00100), .B_ADDR_I(18'h00200), .MEM_WORD_I(mw),
    .DEC_DIGITS_I(dd), .DEC_NEG_I(dn), .INT_A_I(ia), .INT_B_I(ib),
    .LD_I(ld_en), .LD_SEL_I(ld_sel), .LD_DATA_I(ld_data),
    .RD_SEL_I(rd_sel), .RD_DATA_O(rd), .DONE_O(done), .BRANCH_O(br),
    .AAR_O(a_address_register), .BAR_O(bar), .DEC_WR_O(decw), .DEC_DIGITS_O(decd),
    .DEC_NEG_O(decn), .PROD_WR_O(pw), .PROD_O(prod),
    .MPY_OVF_O(ind[0]), .EXP_OVF_O(ind[1]), .DIV_CHK_O(ind[2]));
  task automatic chk(input string w, input logic [47:0] e,
      input logic [47:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask : chk
  task automatic go(input logic [5:0] o, input logic [5:0] a,
      input logic [5:0] b, input logic [47:0] ab, input logic [44:0] d);
    bit ok;
    mdl_u.issue(o, a, b, ab, d, ok);
    chk("done", 1'b1, ok);
    if (!ok) finish_test();
  endtask : go
  // Load pulse one cycle
  task automatic ld(input logic [2:0] s, input logic [47:0] d);
    @(posedge clk);
    #1;
    {ld_en, ld_sel, ld_data} = {1'b1, s, d};
    @(posedge clk);
    #1;
    ld_en = 1'b0;
  endtask : ld
  task automatic rdk(input logic [2:0] s, input logic [47:0] e);
    @(posedge clk);
    #1;
    rd_sel = s;
    @(posedge clk);
    #1;
    chk("readback", e, rd);
  endtask : rdk
  task automatic finish_test;
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("indicators", 3'h0, ind);
    foreach (rows[i]) begin
      go(6'h07, rows[i].v1, rows[i].v2, 48'h0, 45'h0);
      chk("branch", rows[i].br, br);
    end
    go(6'h05, 6'o0, 6'o0, {24'd3, 24'd5}, 45'h0);
    chk("product", 24'd15, prod);
    chk("product write", 1'b1, pw);
    chk("a register", 18'h000fc, a_address_register);
    chk("b register", 18'h001fc, bar);
    go(6'h05, 6'o0, 6'o0, {24'h001000, 24'h001000}, 45'h0);
    chk("product", 24'h0, prod);
    chk("indicators", 3'h1, ind);
    go(6'h07, 6'o01, 6'h05, 48'h0, 45'h0);
    chk("branch", 1'b1, br);
    chk("indicators", 3'h0, ind);
    ld(3'h1, TWO);
    go(6'h07, 6'o12, 6'h0a, 48'h0, 45'h0);
    rdk(3'h2, FOUR);
    rdk(3'h4, 48'h0);
    chk("a register", 18'h000f8, a_address_register);
    go(6'h06, 6'o12, 6'h0a, 48'h0, 45'h0);
    rdk(3'h2, TWO);
    go(6'h06, 6'o32, 6'h0a, 48'h0, 45'h0);
    chk("indicators", 3'h4, ind);
    rdk(3'h2, TWO);
    go(6'h07, 6'o06, 6'h05, 48'h0, 45'h0);
    chk("branch", 1'b1, br);
    chk("indicators", 3'h0, ind);
    go(6'h07, 6'o00, 6'h03, 48'h0, {1'b0, 44'h12345});
    chk("a register", 18'h000f5, a_address_register);
    rdk(3'h0, DTB_Y);
    rdk(3'h4, 48'h0);
    go(6'h07, 6'o00, 6'h06, 48'h0, 45'h0);
    chk("digits", {1'b0, 44'h12345}, {decn, decd});
    chk("decimal write", 1'b1, decw);
    rdk(3'h0, DTB_Y);
    ld(3'h0, {12'h005, 1'b1, 35'h1});
    go(6'h04, 6'o04, 6'h04, 48'h0, 45'h0);
    rdk(3'h0, {12'h000, 1'b1, 35'h10});
    ld(3'h0, {12'h005, 1'b1, 35'h7ffffffff});
    go(6'h04, 6'o05, 6'd63, 48'h0, 45'h0);
    rdk(3'h0, {12'h000, 1'b1, 35'h0});
    finish_test();
  end
endmodule : scientific_float_unit_tb
bind sfu_top sfu_properties #(.ADDR_W(ADDR_W)) prop_u (.*);
